/* File: hw/switch_gpio_control.sv */
// eight general-purpose pins behind one upstream configuration register
//
// Operation
// - bit 4n shows synchronised pin level, resets 1
// - bit 4n+1 selects direction, 1 means output
// - output pin drives bit 4n+2, resets 0
// - pin 0 value only while feature 1 off
// - pin 1 value only while feature 2 off
// - eight 4-bit groups, pin 7 at 28-30
// - register exists only in upstream port space
`timescale 1ns/1ns
`include "switch_gpio_control_defines.svh"

module switch_gpio_control (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire switch_gpio_control_pkg::cfg_req_t cfg_req_i,
    output switch_gpio_control_pkg::cfg_rsp_t cfg_rsp_o,
    input wire logic [1:0] port_power_event_feature_en_i,
    input wire logic [1:0] port_power_event_out_i,
    input wire logic [7:0] pin_in_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_n_o
);

    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    logic [7:0] in_meta_ff;
    logic [7:0] in_sync_ff;

    // both stages reset high so the input bits read 1 after reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            in_meta_ff <= `PIN_IN_RST;
            in_sync_ff <= `PIN_IN_RST;
        end else begin
            in_meta_ff <= pin_in_i;
            in_sync_ff <= in_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // register write
    // ----------------------------------------------------------------
    logic [7:0] dir_ff;
    logic [7:0] val_ff;
    logic hit;
    logic wr_hit;
    logic [7:0] wr_dir;
    logic [7:0] wr_val;

    // downstream ports never decode this offset
    assign hit = cfg_req_i.upstream
        && (cfg_req_i.addr == `PIN_CONTROL_OFS);
    assign wr_hit = cfg_req_i.wr && hit;

    // pull the direction and value bits of every group out of the write word;
    // the input and reserved bits of the word are never looked at
    always_comb begin
        for (int n = 0; n < `PIN_COUNT; n++) begin
            wr_dir[n] = cfg_req_i.wdata[n*`PIN_GROUP_W+`PIN_DIR_POS];
            wr_val[n] = cfg_req_i.wdata[n*`PIN_GROUP_W+`PIN_VAL_POS];
        end
    end

    // each byte lane carries two pin groups; reserved bits are dropped
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            dir_ff <= `PIN_DIR_RST;
            val_ff <= `PIN_VAL_RST;
        end else if (wr_hit) begin
            for (int n = 0; n < `PIN_COUNT; n++) begin
                if (cfg_req_i.be[n/2]) begin
                    dir_ff[n] <= wr_dir[n];
                    val_ff[n] <= wr_val[n];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic rvalid_ff;

    // pack the groups; the fourth bit of every group stays zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hit) begin
            for (int n = 0; n < `PIN_COUNT; n++) begin
                nxt_rdata[n*`PIN_GROUP_W+`PIN_IN_POS] = in_sync_ff[n];
                nxt_rdata[n*`PIN_GROUP_W+`PIN_DIR_POS] = dir_ff[n];
                nxt_rdata[n*`PIN_GROUP_W+`PIN_VAL_POS] = val_ff[n];
            end
        end
    end

    // answer one cycle after every read; unmapped reads return zero
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            rvalid_ff <= cfg_req_i.rd;
            rdata_ff <= cfg_req_i.rd ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign cfg_rsp_o.valid = rvalid_ff;
    assign cfg_rsp_o.data = rdata_ff;

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    logic [7:0] nxt_out;
    logic [7:0] out_ff;

    // the power event logic takes over pins 0 and 1 while enabled
    always_comb begin
        nxt_out = val_ff;
        if (port_power_event_feature_en_i[0]) begin
            nxt_out[0] = port_power_event_out_i[0];
        end
        if (port_power_event_feature_en_i[1]) begin
            nxt_out[1] = port_power_event_out_i[1];
        end
    end

    // registered so the pads see no decode glitches
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            out_ff <= `PIN_VAL_RST;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign pin_out_o = out_ff;
    assign pin_oe_n_o = ~dir_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    logic rst_seen_ff;
    always_ff @(posedge clk_sys_i) begin
        rst_seen_ff <= srst_i;
    end

    chk_in_reset_high: assert property (
        rst_seen_ff |-> in_sync_ff == 8'hff)
        else $error("input bits not high after reset");

    chk_in_two_stage: assert property (
        !rst_seen_ff && !$past(rst_seen_ff)
        |-> in_sync_ff == $past(pin_in_i, 2))
        else $error("input bit not two cycles behind pin");

    chk_dir_reset_input: assert property (
        rst_seen_ff |-> pin_oe_n_o == 8'hff && pin_out_o == 8'h00)
        else $error("pins not inputs after reset");

    chk_dir_write_takes: assert property (
        wr_hit && cfg_req_i.be[0]
        |=> pin_oe_n_o[0] == !$past(cfg_req_i.wdata[1]))
        else $error("direction write not applied");

    chk_val_to_pin: assert property (
        wr_hit && cfg_req_i.be[1]
        |-> ##2 pin_out_o[2] == $past(cfg_req_i.wdata[10], 2))
        else $error("output value not driven on pin 2");

    chk_pin0_feature: assert property (
        port_power_event_feature_en_i[0]
        |=> pin_out_o[0] == $past(port_power_event_out_i[0]))
        else $error("pin 0 not owned by power event feature");

    chk_pin1_feature: assert property (
        !port_power_event_feature_en_i[1]
        |=> pin_out_o[1] == $past(val_ff[1]))
        else $error("pin 1 value bit ignored while feature off");

    chk_pin7_group: assert property (
        cfg_req_i.rd && hit
        |=> cfg_rsp_o.data[30:28] ==
            {$past(val_ff[7]), $past(dir_ff[7]), $past(in_sync_ff[7])})
        else $error("pin 7 group misplaced");

    chk_downstream_zero: assert property (
        cfg_req_i.rd && !cfg_req_i.upstream
        |=> cfg_rsp_o.valid && cfg_rsp_o.data == 32'h0000_0000)
        else $error("downstream read returned data");

    chk_downstream_nowrite: assert property (
        cfg_req_i.wr && !cfg_req_i.upstream
        |=> $stable(dir_ff) && $stable(val_ff))
        else $error("downstream write changed register");

    chk_rsvd_zero: assert property (
        cfg_rsp_o.valid |-> (cfg_rsp_o.data & 32'h8888_8888) == 32'h0000_0000)
        else $error("reserved bit read as one");

    // pin 0 must follow its value bit again once the feature lets go
    chk_pin0_value: assert property (
        !port_power_event_feature_en_i[0]
        |=> pin_out_o[0] == $past(val_ff[0]))
        else $error("pin 0 value bit ignored while feature off");

    chk_pin1_owned: assert property (
        port_power_event_feature_en_i[1]
        |=> pin_out_o[1] == $past(port_power_event_out_i[1]))
        else $error("pin 1 not owned by power event feature");

    // a lane left out of the byte enables keeps both of its pin groups
    chk_lane_mask: assert property (
        wr_hit && !cfg_req_i.be[1]
        |=> $stable(dir_ff[3:2]) && $stable(val_ff[3:2]))
        else $error("masked lane changed pins 2 and 3");

    chk_pin7_dir: assert property (
        wr_hit && cfg_req_i.be[3]
        |=> pin_oe_n_o[7] == !$past(cfg_req_i.wdata[29]))
        else $error("pin 7 direction not taken from bit 29");

    // main scenarios the bench is expected to reach
    cov_pin_output: cover property (wr_hit ##1 pin_oe_n_o != 8'hff);
    cov_read_back: cover property (cfg_req_i.rd && hit ##1 cfg_rsp_o.valid);
    cov_feature_take: cover property (
        port_power_event_feature_en_i == 2'b11 && dir_ff[1:0] == 2'b11);
    cov_downstream_read: cover property (
        cfg_req_i.rd && !cfg_req_i.upstream ##1 cfg_rsp_o.valid);

endmodule // switch_gpio_control

/* File: hw/switch_gpio_control_defines.svh */
// offsets, field positions, reset values for the pin control block
`ifndef SWITCH_GPIO_CONTROL_DEFINES_SVH
`define SWITCH_GPIO_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PIN_CONTROL_OFS 12'h0b8
`define PIN_COUNT 8
`define PIN_GROUP_W 4

// ----------------------------------------------------------------
// field positions inside one 4-bit pin group
// ----------------------------------------------------------------
`define PIN_IN_POS 0
`define PIN_DIR_POS 1
`define PIN_VAL_POS 2
`define PIN_RSVD_POS 3

// ----------------------------------------------------------------
// reset values, one bit per pin
// ----------------------------------------------------------------
`define PIN_IN_RST 8'hff
`define PIN_DIR_RST 8'h00
`define PIN_VAL_RST 8'h00

`endif

/* File: hw/switch_gpio_control_pkg.sv */
// types shared by the pin control block
package switch_gpio_control_pkg;

    // one configuration-space access, as the config decoder hands it over
    typedef struct packed {
        logic wr;
        logic rd;
        logic upstream;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // answer to a read
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } cfg_rsp_t;

endpackage

/* File: bench/board_model.sv */
// board-side model of the eight general-purpose pins
`timescale 1ns/1ns

module board_model (
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] pin_oe_n_i,
    input wire logic [7:0] board_drv_i,
    output logic [7:0] pin_level_o
);
    // per pin, the device wins while its enable is low, else the board drives
    // contention is not modelled: the board is taken to drive weakly
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pin_level_o[n] = pin_oe_n_i[n] ? board_drv_i[n] : pin_out_i[n];
        end
    end
endmodule // board_model

/* File: bench/testbench.sv */
// self-checking bench for the pin control register block
`timescale 1ns/1ns

module testbench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    switch_gpio_control_pkg::cfg_req_t req = '0;
    switch_gpio_control_pkg::cfg_rsp_t rsp;
    logic [1:0] feat_en = 2'b00;
    logic [1:0] feat_out = 2'b00;
    logic [7:0] board_drv = 8'hff;
    logic [7:0] pin_lvl, pin_out, pin_oe_n;
    int err_count = 0;
    int num_checks = 0;

    switch_gpio_control u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .cfg_req_i(req), .cfg_rsp_o(rsp),
        .port_power_event_feature_en_i(feat_en),
        .port_power_event_out_i(feat_out), .pin_in_i(pin_lvl),
        .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n));
    board_model u_board (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
        .board_drv_i(board_drv), .pin_level_o(pin_lvl));

    // ----------------------------------------------------------------
    // clock, checks and bus tasks
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access: raised after an edge, held until the taking edge
    task automatic cfg_wr(input logic up, input logic [11:0] addr,
            input logic [3:0] be, input logic [31:0] data);
        @(posedge clk_sys_i);
        req <= {1'b1, 1'b0, up, addr, be, data};
        @(posedge clk_sys_i);
        req <= '0;
    endtask

    // read answer is looked at in its one valid cycle
    task automatic cfg_rd(input logic up, input logic [11:0] addr,
            input logic [31:0] exp);
        @(posedge clk_sys_i);
        req <= {1'b0, 1'b1, up, addr, 4'h0, 32'h0000_0000};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        chk("rsp_valid", 32'h0000_0001, {31'h0, rsp.valid});
        chk("rsp_data", exp, rsp.data);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        idle(3);
        chk("oe_rst", 32'h0000_00ff, {24'h0, pin_oe_n});
        cfg_rd(1'b1, 12'h0b8, 32'h1111_1111);
        $display("test reset done");
        // all ones: reserved bits must stay zero, all pins drive high
        cfg_wr(1'b1, 12'h0b8, 4'hf, 32'hffff_ffff);
        idle(3);
        chk("oe_out", 32'h0000_0000, {24'h0, pin_oe_n});
        chk("pin_out", 32'h0000_00ff, {24'h0, pin_out});
        cfg_rd(1'b1, 12'h0b8, 32'h7777_7777);
        $display("test drive done");
        // feature on takes pins 0 and 1 away from the value bits; both
        // feature values differ from the value bits so each takeover shows
        @(posedge clk_sys_i);
        feat_en <= 2'b11;
        feat_out <= 2'b00;
        idle(3);
        chk("pin_feat", 32'h0000_00fc, {24'h0, pin_out});
        @(posedge clk_sys_i);
        feat_en <= 2'b00;
        idle(3);
        chk("pin_nofeat", 32'h0000_00ff, {24'h0, pin_out});
        $display("test feature done");
        // lane 0 only, then downstream and other-offset accesses
        cfg_wr(1'b1, 12'h0b8, 4'h1, 32'h0000_0000);
        cfg_wr(1'b0, 12'h0b8, 4'hf, 32'h0000_0000);
        cfg_wr(1'b1, 12'h0bc, 4'hf, 32'h0000_0000);
        idle(3);
        cfg_rd(1'b1, 12'h0b8, 32'h7777_7711);
        cfg_rd(1'b0, 12'h0b8, 32'h0000_0000);
        cfg_rd(1'b1, 12'h0bc, 32'h0000_0000);
        $display("test access done");
        // inputs follow the board pattern once released
        cfg_wr(1'b1, 12'h0b8, 4'hf, 32'h0000_0000);
        board_drv <= 8'h5a;
        idle(4);
        cfg_rd(1'b1, 12'h0b8, 32'h0101_1010);
        $display("test inputs done");
        stop_test();
    end

    // watchdog well beyond the some 60 cycles the tests need
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // testbench
